// ===== shared/pcr_map.vh
// Register offsets, field positions, reset values and timing counts of the card reader controller.
`ifndef PCR_MAP_VH
`define PCR_MAP_VH
// Word indices of the four registers within the block's address window.
`define PCR_IDX_STATUS   2'h0
`define PCR_IDX_RAW      2'h1
`define PCR_IDX_PACKED   2'h2
`define PCR_IDX_MAINT    2'h3
// Default base of the address window (byte address, word index in bits 2:1).
`define PCR_BASE_DEFAULT 16'hff70
// Field positions of the control_status_word.
`define PCR_BIT_ERROR    15
`define PCR_BIT_CDONE    14
`define PCR_BIT_SUPPLY   13
`define PCR_BIT_FEED     12
`define PCR_BIT_OVERRUN  11
`define PCR_BIT_ONTRANS  10
`define PCR_BIT_BUSY     9
`define PCR_BIT_OFFLINE  8
`define PCR_BIT_COLAV    7
`define PCR_BIT_IEN      6
`define PCR_BIT_DISCARD  1
`define PCR_BIT_READ     0
// Reset value of every control flip-flop.
`define PCR_RST_CTRL     1'b0
`define PCR_RST_COL      12'h000
// Cycles after reset before pin edges count; covers the filter depth plus one.
`define PCR_WARM_CYCLES  3'h6
`endif

// ===== src/pcr_controller.v
// Card reader controller: register slave, column capture, flags and interrupt request.
`timescale 1ns/100ps
`include "pcr_map.vh"
module pcr_controller #(
    parameter [15:0] BASE_ADDR = `PCR_BASE_DEFAULT  // Window base; moved per installation by this parameter.
) (
    input  wire        core_clk,        // System clock, 50 MHz.
    input  wire        resetn,          // Asynchronous reset, active low.
    input  wire        bus_init,        // Synchronous bus initialize, active high.
    input  wire [15:0] bus_addr,        // Byte address of the access.
    input  wire [15:0] bus_wdata,       // Write data.
    input  wire        bus_wr,          // One-cycle write strobe.
    input  wire        bus_rd,          // One-cycle read strobe.
    output reg  [15:0] bus_rdata,       // Read data, valid the cycle after bus_rd.
    output reg         bus_rvalid,      // High in the cycle that read data stand.
    input  wire        rdr_online,      // Reader on-line level (pin).
    input  wire        rdr_busy,        // Reader processing a card (pin).
    input  wire        supply_alarm,    // Hopper empty or stacker full (pin).
    input  wire        feed_alarm,      // Pick or motion failure (pin).
    input  wire [11:0] rdr_data,        // Column data lines (pins).
    input  wire        rdr_strobe,      // Column strobe (pin).
    output wire        rdr_read_cmd,    // Start-read command to the reader.
    output wire        irq              // Interrupt request, level.
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Returns one when the address falls in the four-word window.
    function hit;
        input [15:0] a;
        begin
            hit = (a[15:3] == BASE_ADDR[15:3]);
        end
    endfunction

    // Compresses a 12-bit column to 8 bits; rows 1..7 are assumed single punched.
    // Double punches in rows 1..7 are not legal codes, so the result is then only a best guess.
    function [7:0] pack;
        input [11:0] c;
        reg   [2:0]  code;
        reg   [3:0]  row;                // Row number of the punch under test.
        integer      i;
        begin
            code = 3'h0;
            row  = 4'h0;
            // Rows 1..7 sit at bits 8..2; the lowest punched row wins if doubled.
            for (i = 2; i <= 8; i = i + 1) begin
                if (c[i]) begin
                    row  = 4'h9 - i[3:0];
                    code = row[2:0];
                end
            end
            pack = {c[11:9], c[1], code, c[0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when stages two and three agree.

    localparam integer NPIN = 5;         // Control pins: online, busy, supply, feed, strobe.
    // Control pins gathered so one generate loop filters all of them.
    wire [4:0]  pin_raw = {rdr_strobe, feed_alarm, supply_alarm, rdr_busy, rdr_online};
    reg  [4:0]  s1_ff;                   // First stage; read only by the second.
    reg  [4:0]  s2_ff;                   // Second stage.
    reg  [4:0]  s3_ff;                   // Third stage.
    reg  [4:0]  pin_ff;                  // Filtered level.
    reg  [11:0] d1_ff;                   // Data first stage.
    reg  [11:0] d2_ff;                   // Data second stage.
    reg  [11:0] d3_ff;                   // Data third stage, aligned with the strobe filter.
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_sync
            // Each pin settles independently, so a glitch on one cannot disturb another.
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    s1_ff[g]  <= 1'b0;
                    s2_ff[g]  <= 1'b0;
                    s3_ff[g]  <= 1'b0;
                    pin_ff[g] <= 1'b0;
                end else begin
                    s1_ff[g] <= pin_raw[g];
                    s2_ff[g] <= s1_ff[g];
                    s3_ff[g] <= s2_ff[g];
                    if (s2_ff[g] == s3_ff[g]) begin
                        pin_ff[g] <= s3_ff[g];
                    end
                end
            end
        end
    endgenerate

    // Data lines lag the strobe filter by the same depth so the column is stable at capture.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            d1_ff <= `PCR_RST_COL;
            d2_ff <= `PCR_RST_COL;
            d3_ff <= `PCR_RST_COL;
        end else begin
            d1_ff <= rdr_data;
            d2_ff <= d1_ff;
            d3_ff <= d2_ff;
        end
    end

    // Filtered reader levels; each is a pin after its three-stage filter.
    wire online  = pin_ff[0];
    wire busy    = pin_ff[1];
    wire supply  = pin_ff[2];
    wire feed    = pin_ff[3];
    wire strobe  = pin_ff[4];

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the filtered levels.

    // The filters leave reset at zero while the pins may already be high, so every edge is
    // held off until the filters carry real pin levels; otherwise a reader that is on-line
    // at power-up would look like a fresh transition. An edge inside this window is lost.
    reg  [2:0] warm_ff;                 // Cycles since reset, saturating at the warm-up count.
    wire       warm = (warm_ff == `PCR_WARM_CYCLES);

    // Warm-up counter; it only moves while the filters are still settling.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            warm_ff <= 3'h0;
        end else if (!warm) begin
            warm_ff <= warm_ff + 3'h1;
        end
    end

    reg  online_d_ff;                   // Previous online level.
    reg  busy_d_ff;                     // Previous busy level.
    reg  strobe_d_ff;                   // Previous strobe level.
    // Edges are one-cycle pulses in the core clock domain.
    wire online_rise = warm & online & ~online_d_ff;
    wire online_fall = warm & ~online & online_d_ff;
    wire card_exit   = warm & ~busy & busy_d_ff;
    wire col_strobe  = warm & strobe & ~strobe_d_ff;

    // Previous levels, one cycle behind the filters.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            online_d_ff <= 1'b0;
            busy_d_ff   <= 1'b0;
            strobe_d_ff <= 1'b0;
        end else begin
            online_d_ff <= online;
            busy_d_ff   <= busy;
            strobe_d_ff <= strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // Writes to the data registers clear column_available too, since the buffer is addressed.
    wire       sel       = hit(bus_addr);
    wire [1:0] idx       = bus_addr[2:1];
    wire       wr_status = bus_wr & sel & (idx == `PCR_IDX_STATUS);
    wire       data_acc  = (bus_wr | bus_rd) & sel &
                           ((idx == `PCR_IDX_RAW) | (idx == `PCR_IDX_PACKED));

    ////////////////////////////////////////////////////////////////////////////
    // Control and flag registers.

    reg        ien_ff;                  // Interrupt enable.
    reg        read_ff;                 // Start-read command held until the card starts.
    reg        discard_ff;              // Discard option.
    reg        colav_ff;                // column_available.
    reg        cdone_ff;                // card_complete.
    reg        overrun_ff;              // overrun_error.
    reg        ontrans_ff;              // online_transition.
    reg        error_ff;                // Error flag.
    reg [11:0] col_ff;                  // Column buffer.
    // Next-state values of the two column flags.
    reg        nxt_colav;
    reg        nxt_overrun;

    // Column flag logic; the strobe set wins over a same-cycle clear.
    always @* begin
        nxt_colav   = colav_ff;
        nxt_overrun = overrun_ff;
        if (wr_status) begin
            nxt_overrun = 1'b0;
        end
        if (data_acc) begin
            nxt_colav = 1'b0;
        end
        if (col_strobe) begin
            if (colav_ff && !discard_ff) begin
                nxt_overrun = 1'b1;
                nxt_colav   = 1'b0;
            end else if (!overrun_ff && !discard_ff) begin
                nxt_colav   = 1'b1;
            end
        end
    end

    // Flag and control registers; bus initialize behaves as reset.
    // A limitation: bus initialize leaves the column buffer as it was.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ien_ff     <= `PCR_RST_CTRL;
            read_ff    <= `PCR_RST_CTRL;
            discard_ff <= `PCR_RST_CTRL;
            colav_ff   <= `PCR_RST_CTRL;
            cdone_ff   <= `PCR_RST_CTRL;
            overrun_ff <= `PCR_RST_CTRL;
            ontrans_ff <= `PCR_RST_CTRL;
            error_ff   <= `PCR_RST_CTRL;
            col_ff     <= `PCR_RST_COL;
        end else if (bus_init) begin
            ien_ff     <= 1'b0;
            read_ff    <= 1'b0;
            discard_ff <= 1'b0;
            colav_ff   <= 1'b0;
            cdone_ff   <= 1'b0;
            overrun_ff <= 1'b0;
            ontrans_ff <= 1'b0;
            error_ff   <= 1'b0;
        end else begin
            colav_ff   <= nxt_colav;
            overrun_ff <= nxt_overrun;
            if (col_strobe) begin
                col_ff <= d3_ff;
            end
            if (wr_status) begin
                ien_ff     <= bus_wdata[`PCR_BIT_IEN];
                discard_ff <= bus_wdata[`PCR_BIT_DISCARD];
                // A read is refused while an error is pending.
                read_ff    <= bus_wdata[`PCR_BIT_READ] & ~error_ff;
            end else if (busy) begin
                read_ff <= 1'b0;            // The reader has taken the card.
            end
            // Loading the status clears the event flags, the error flag only while on-line; a same-cycle event still sets them.
            cdone_ff   <= card_exit | (cdone_ff & ~wr_status);
            ontrans_ff <= online_rise | (ontrans_ff & ~wr_status);
            error_ff   <= online_fall | (card_exit & overrun_ff) |
                          (error_ff & ~(wr_status & online));
        end
    end

    // The command is the only signal sent to the reader; it stays up until busy shows the card moving.
    assign rdr_read_cmd = read_ff;

    // Any flag raises the request when enabled; overrun reports through the error flag.
    assign irq = ien_ff & (error_ff | ~online | cdone_ff | ontrans_ff | colav_ff);

    ////////////////////////////////////////////////////////////////////////////
    // Read data path: one cycle after the strobe, zero for unmapped or write-only.

    // Status image: reader levels, controller flags, and the command bits that read back.
    wire [15:0] status_word;
    assign status_word = {error_ff, cdone_ff, supply, feed, overrun_ff, ontrans_ff,
                          busy, ~online, colav_ff, ien_ff, 4'h0, discard_ff, 1'b0};

    // Read data register; it returns to zero after one cycle so stale words never linger.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata  <= 16'h0000;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rvalid <= bus_rd;
            bus_rdata  <= 16'h0000;
            if (bus_rd && sel) begin
                case (idx)
                    `PCR_IDX_STATUS: bus_rdata <= status_word;
                    `PCR_IDX_RAW:    bus_rdata <= {4'h0, col_ff};
                    `PCR_IDX_PACKED: bus_rdata <= {8'h00, pack(col_ff)};
                    default:         bus_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule // pcr_controller

// ===== verification/pcr_controller_chk.sv
// Port assertions for the card reader controller.
`timescale 1ns/100ps
`include "pcr_map.vh"
module pcr_controller_chk #(parameter [15:0] BASE_ADDR = `PCR_BASE_DEFAULT) (
    input wire        core_clk,
    input wire        resetn,
    input wire        bus_init,
    input wire [15:0] bus_addr,
    input wire        bus_rd,
    input wire [15:0] bus_rdata,
    input wire        bus_rvalid,
    input wire        rdr_busy,
    input wire        rdr_read_cmd,
    input wire        irq
);
    // Window hit and register index of the access.
    wire       hit = bus_addr[15:3] == BASE_ADDR[15:3];
    wire [1:0] idx = bus_addr[2:1];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_read_answer: assert property (bus_rd |=> bus_rvalid)
        else $error("read not answered");
    a_idle_quiet: assert property (!bus_rd |=> !bus_rvalid && bus_rdata == 16'h0000)
        else $error("data outside a read");
    a_unmapped_zero: assert property (bus_rd && (!hit || idx == `PCR_IDX_MAINT) |=> bus_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_read_bit_zero: assert property (bus_rd && hit && idx == `PCR_IDX_STATUS |=> !bus_rdata[`PCR_BIT_READ])
        else $error("start bit read back");
    a_raw_width: assert property (bus_rd && hit && idx == `PCR_IDX_RAW |=> bus_rdata[15:12] == 4'h0)
        else $error("raw upper bits set");
    a_packed_byte: assert property (bus_rd && hit && idx == `PCR_IDX_PACKED |=> bus_rdata[15:8] == 8'h00)
        else $error("packed high byte set");
    // The request seen at the read equals the enable anded with the flags that read returned.
    a_irq_flags: assert property (bus_rd && hit && idx == `PCR_IDX_STATUS |=>
        $past(irq) == (bus_rdata[`PCR_BIT_IEN] && (|(bus_rdata & 16'hc580))))
        else $error("request differs from flags");
    a_init_clears: assert property (bus_init |=> !irq && !rdr_read_cmd)
        else $error("init left request or command");
    // The command is a level held only until the reader shows it has taken the card.
    a_cmd_released: assert property ($rose(rdr_busy) && rdr_read_cmd |-> ##[1:8] !rdr_read_cmd)
        else $error("command not released");
    c_column: cover property (bus_rd ##1 bus_rdata[`PCR_BIT_COLAV]);
    c_irq: cover property ($rose(irq));
    c_cmd: cover property ($rose(rdr_read_cmd));
endmodule // pcr_controller_chk
bind pcr_controller pcr_controller_chk #(.BASE_ADDR(BASE_ADDR)) i_pcr_controller_chk (.core_clk, .resetn,
    .bus_init, .bus_addr, .bus_rd, .bus_rdata, .bus_rvalid, .rdr_busy, .rdr_read_cmd, .irq);

// ===== verification/pcr_controller_test.sv
// Self-checking bench for the card reader controller.
`timescale 1ns/100ps
`include "pcr_map.vh"
module pcr_controller_test;
    localparam [15:0] ST = `PCR_BASE_DEFAULT;
    localparam [15:0] RAW = ST + 16'h2;
    localparam [15:0] PK = ST + 16'h4;
    reg          core_clk = 1'b0, resetn = 1'b0, bus_init = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    reg   [15:0] bus_addr = 16'h0, bus_wdata = 16'h0;
    wire  [15:0] bus_rdata;
    wire  [11:0] rdr_data;
    wire         bus_rvalid, rdr_online, rdr_busy, supply_alarm, feed_alarm, rdr_strobe, rdr_read_cmd, irq;
    reg   [1:0]  fault = 2'h0;
    reg   [3:0]  gap = 4'h4;
    logic [15:0] exp_q[$], pk[0:2];
    logic [11:0] rw[0:2], col;
    int          mismatches = 0, n_tests = 0, c, j, k;
    pcr_controller i_pcr_controller (.core_clk, .resetn, .bus_init, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
        .bus_rdata, .bus_rvalid, .rdr_online, .rdr_busy, .supply_alarm, .feed_alarm, .rdr_data, .rdr_strobe,
        .rdr_read_cmd, .irq);
    pcr_reader_model i_pcr_reader_model (.rdr_read_cmd, .fault, .gap, .rdr_online, .rdr_busy,
        .supply_alarm, .feed_alarm, .rdr_data, .rdr_strobe);
    initial forever #10 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask
    // A read notes its expected word; the watcher below compares it when the answer stands.
    task rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk);
        bus_rd <= 1'b0;
    endtask
    always @(posedge core_clk) begin
        if (bus_rvalid === 1'b1) begin
            if (exp_q.size() == 0) chk("read count", 16'h0, 16'hffff);
            else chk("read data", exp_q.pop_front(), bus_rdata);
        end
    end
    // Sampling on the falling edge keeps the loops clear of the design's own updates.
    // The first falling edge lets a flag cleared by the access just made settle before it is looked at.
    task wait_irq;
        @(negedge core_clk);
        for (k = 0; k < 500 && irq !== 1'b1; k++) @(negedge core_clk);
        chk("irq", 16'h1, {15'h0, irq});
    endtask
    task wait_card;
        for (k = 0; k < 500 && rdr_busy !== 1'b1; k++) @(negedge core_clk);
        chk("card start", 16'h1, {15'h0, rdr_busy});
        for (k = 0; k < 2000 && rdr_busy !== 1'b0; k++) @(negedge core_clk);
        chk("card end", 16'h0, {15'h0, rdr_busy});
        repeat (10) @(posedge core_clk);
    endtask
    // Random columns hold at most one punch in rows one to seven, the only case that packs cleanly.
    task load(input logic [3:0] g);
        gap = g;
        for (c = 0; c < 3; c++) begin
            j = $urandom % 8;
            col = 12'($urandom) & 12'he03;
            if (j != 0) col[9 - j] = 1'b1;
            rw[c] = col;
            pk[c] = {8'h00, col[11:9], col[1], 3'(j), col[0]};
            i_pcr_reader_model.cols[c] = col;
        end
    endtask
    task conclude;
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        conclude();
    end
    initial begin
        j = $urandom(66668);
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (10) @(posedge core_clk);
        wr(ST, 16'h0000);
        rd(ST, 16'h0000);
        wr(16'hff78, 16'h0041);
        rd(16'hff78, 16'h0000);
        rd(ST + 16'h6, 16'h0000);
        rd(ST, 16'h0000);
        load(4'h4);
        wr(ST, 16'h0041);
        for (c = 0; c < 3; c++) begin
            wait_irq();
            rd(ST, 16'h02c0);
            rd(RAW, {4'h0, rw[c]});
            rd(ST, 16'h0240);
            rd(PK, pk[c]);
        end
        wait_irq();
        rd(ST, 16'h4040);
        wr(ST, 16'h0040);
        rd(ST, 16'h0040);
        load(4'h0);
        wr(ST, 16'h0003);
        wait_card();
        rd(ST, 16'h4002);
        rd(RAW, {4'h0, rw[2]});
        chk("irq", 16'h0, {15'h0, irq});
        wr(ST, 16'h0000);
        load(4'h0);
        wr(ST, 16'h0001);
        wait_card();
        rd(ST, 16'hc800);
        wr(ST, 16'h0000);
        rd(ST, 16'h0000);
        wr(ST, 16'h0040);
        for (c = 1; c < 3; c++) begin
            fault <= 2'(c);
            repeat (10) @(posedge core_clk);
            wr(ST, 16'h0041);
            rd(ST, c == 1 ? 16'ha140 : 16'h9140);
            @(negedge core_clk);
            chk("irq", 16'h1, {15'h0, irq});
            chk("read command", 16'h0, {15'h0, rdr_read_cmd});
        end
        fault <= 2'h0;
        repeat (10) @(posedge core_clk);
        rd(ST, 16'h8440);
        wr(ST, 16'h0040);
        rd(ST, 16'h0040);
        @(posedge core_clk);
        bus_init <= 1'b1;
        @(posedge core_clk);
        bus_init <= 1'b0;
        rd(ST, 16'h0000);
        repeat (3) @(posedge core_clk);
        conclude();
    end
endmodule // pcr_controller_test

// ===== verification/pcr_reader_model.sv
// Behavioural card reader that feeds three columns per start command.
`timescale 1ns/100ps
module pcr_reader_model (
    input  wire        rdr_read_cmd,
    input  wire [1:0]  fault,
    input  wire [3:0]  gap,
    output wire        rdr_online,
    output reg         rdr_busy,
    output wire        supply_alarm,
    output wire        feed_alarm,
    output reg  [11:0] rdr_data,
    output reg         rdr_strobe
);
    reg [11:0] cols [0:2];  // Column images, loaded by the bench.
    integer    i;
    // Any alarm drops the on-line level; the code picks the extra alarm line.
    assign rdr_online   = fault == 2'h0;
    assign supply_alarm = fault == 2'h1;
    assign feed_alarm   = fault == 2'h2;
    initial begin
        rdr_busy   = 1'b0;
        rdr_data   = 12'h5a5;
        rdr_strobe = 1'b0;
    end
    // One card per command; data lines show the inverse once a strobe is over, so stale data never matches.
    always begin
        wait (rdr_read_cmd && fault == 2'h0);
        #200 rdr_busy = 1'b1;
        for (i = 0; i < 3; i = i + 1) begin
            #(160 * gap) rdr_data = cols[i];
            #160 rdr_strobe = 1'b1;
            #80 rdr_strobe = 1'b0;
            #80 rdr_data = ~cols[i];
        end
        #(160 * gap + 160) rdr_busy = 1'b0;
        wait (!rdr_read_cmd);
    end
endmodule // pcr_reader_model
